//--- srm_block_ram.sv
// One memory block: 1024 words of 8 bits, one bit lane per part.
// Assumes the write strobe is already gated by phase two and select.
`timescale 1ns/1ns
module srm_block_ram #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          clk_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic          select_n,
    input  wire logic          write_strobe_n,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    wire do_write = clk_en & ~select_n & ~write_strobe_n;

    // Repeated writes within one strobe store the same word again
    always_ff @(posedge clk)
    begin
        if (do_write)
        begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule : srm_block_ram

//--- srm_cpu_model.sv
// Processor bus model driving address, qualifier, direction and phase two.
// Assumes tasks are entered just after a rising clk edge.
`timescale 1ns/1ns
module srm_cpu_model (
    input wire logic        clk,
    input wire logic [7:0]  data_out,
    input wire logic        data_oe,
    input wire logic        memory_ready,
    output logic     [15:0] addr,
    output logic            valid_access_qualifier,
    output logic            read_write,
    output logic            phi2,
    output logic     [7:0]  data_in
);
    // Set when the last cycle saw memory ready low and stretched phase two
    logic stretched;
    initial
    begin
        stretched = 1'b0;
        addr = 16'h0000;
        valid_access_qualifier = 1'b0;
        read_write = 1'b1;
        phi2 = 1'b0;
        data_in = 8'h00;
    end
    task cycle(input logic r, input logic [15:0] a, input logic [7:0] w,
               output logic [7:0] rd, output logic oe);
        addr <= a;
        valid_access_qualifier <= 1'b1;
        read_write <= r;
        data_in <= w;
        @(posedge clk);
        phi2 <= 1'b1;
        stretched = (memory_ready !== 1'b1);
        if (stretched)
            @(posedge clk);
        @(posedge clk);
        rd = data_out;
        oe = data_oe;
        phi2 <= 1'b0;
        @(posedge clk);
        // Data held one cycle past phase two, then left invalid
        valid_access_qualifier <= 1'b0;
        read_write <= 1'b1;
        data_in <= ~w;
        // Let the release stand a cycle before the next request drives again
        @(posedge clk);
    endtask : cycle
endmodule : srm_cpu_model

//--- srm_module.sv
// Top of the static RAM module: two relocatable blocks, control logic,
// and an APB register file holding the switch settings.
// Assumes processor bus inputs are synchronous to CLK at 10 MHz.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
module srm_module #(
    parameter int ADDR_W = srm_pkg::ADDR_W,
    parameter int BLK_AW = srm_pkg::BLK_AW,
    parameter int DATA_W = srm_pkg::DATA_W
) (
    input  wire logic                        CLK,
    input  wire logic                        RSTN,
    input  wire logic                        CLK_EN,
    // APB slave
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [srm_pkg::PADDR_W-1:0] PADDR,
    input  wire logic [31:0]                 PWDATA,
    output logic      [31:0]                 PRDATA,
    output logic                             PREADY,
    output logic                             PSLVERR,
    // Processor bus
    input  wire logic [ADDR_W-1:0]           ADDR,
    input  wire logic                        VALID_ACCESS_QUALIFIER,
    input  wire logic                        READ_WRITE,
    input  wire logic                        PHI2,
    input  wire logic [DATA_W-1:0]           DATA_IN,
    output logic      [DATA_W-1:0]           DATA_OUT,
    output logic                             DATA_OE,
    // Memory side and clock control
    output logic                             BLOCK_ONE_SELECT_N,
    output logic                             BLOCK_TWO_SELECT_N,
    output logic                             MODULE_SELECTED,
    output logic                             READ_DRIVE_ENABLE,
    output logic                             BLOCK_ONE_WRITE_STROBE,
    output logic                             BLOCK_TWO_WRITE_STROBE,
    output logic                             MEMORY_READY
);
    localparam int SEL_W = ADDR_W - BLK_AW;
    localparam int NBLK  = srm_pkg::NUM_BLK;

    // The decode and the register layout only serve a 6-bit upper field
    generate
        if (SEL_W != 6 || DATA_W < 1 || DATA_W > 16)
        begin : g_bad_params
            $error("srm_module: unsupported address or data width");
        end
    endgenerate

    // Base switch field of one block
    function automatic logic [SEL_W-1:0] base_of(
        input logic [31:0] cfg,
        input int          blk
    );
        base_of = cfg[blk*srm_pkg::CFG_BASE_STRIDE +: SEL_W];
    endfunction : base_of

    // Protect switch of one block
    function automatic logic prot_of(
        input logic [31:0] cfg,
        input int          blk
    );
        prot_of = cfg[srm_pkg::CFG_PROT_LSB + blk];
    endfunction : prot_of

    // Register state
    logic [31:0]              cfg_q;
    logic [31:0]              prdata_q;
    logic [31:0]              prdata_d;
    logic [DATA_W-1:0]        dout_q;
    logic [NBLK-1:0]          strobe_prev_q;
    logic [srm_pkg::CNT_W-1:0] wcount_q [NBLK];

    // Block wiring
    logic [NBLK-1:0]          sel_n;
    logic [NBLK-1:0]          strobe_n;
    logic [NBLK-1:0]          strobe_fall;
    logic [DATA_W-1:0]        blk_rdata [NBLK];

    wire slow_parts = cfg_q[srm_pkg::CFG_SLOW_BIT];

    // Per-block select, storage and write gating
    genvar gi;
    generate
        for (gi = 0; gi < NBLK; gi++)
        begin : g_blk
            wire [SEL_W-1:0] base_sw = base_of(cfg_q, gi);
            wire             protect = prot_of(cfg_q, gi);

            srm_select #(
                .SEL_W (SEL_W)
            ) u_select (
                .upper_addr             (ADDR[ADDR_W-1:BLK_AW]),
                .base_sw                (base_sw),
                .valid_access_qualifier (VALID_ACCESS_QUALIFIER),
                .select_n               (sel_n[gi])
            );

            // Strobe low only for a qualified write during phase two
            wire write_ok = ~sel_n[gi] & ~READ_WRITE & ~protect;
            assign strobe_n[gi] =
                ~(write_ok & PHI2 & VALID_ACCESS_QUALIFIER);

            // A falling strobe marks the single write pulse of a bus cycle
            assign strobe_fall[gi] = strobe_prev_q[gi] & ~strobe_n[gi];

            srm_block_ram #(
                .AW (BLK_AW),
                .DW (DATA_W)
            ) u_ram (
                .clk            (CLK),
                .clk_en         (CLK_EN),
                .addr           (ADDR[BLK_AW-1:0]),
                .select_n       (sel_n[gi]),
                .write_strobe_n (strobe_n[gi]),
                .wdata          (DATA_IN),
                .rdata          (blk_rdata[gi])
            );
        end
    endgenerate

    // Control logic
    wire mod_sel  = ~sel_n[0] | ~sel_n[1];
    wire rd_drive = mod_sel & READ_WRITE;

    // Slow parts ask the processor to stretch phase two for this cycle
    wire mem_ready = slow_parts ? ~mod_sel : 1'b1;

    // Block two wins only when block one is not selected
    wire [DATA_W-1:0] read_word = sel_n[0] ? blk_rdata[1] : blk_rdata[0];

    assign BLOCK_ONE_SELECT_N     = sel_n[0];
    assign BLOCK_TWO_SELECT_N     = sel_n[1];
    assign MODULE_SELECTED        = mod_sel;
    assign READ_DRIVE_ENABLE      = rd_drive;
    assign BLOCK_ONE_WRITE_STROBE = strobe_n[0];
    assign BLOCK_TWO_WRITE_STROBE = strobe_n[1];
    assign MEMORY_READY           = mem_ready;
    assign DATA_OE                = rd_drive;
    assign DATA_OUT               = dout_q;

    // APB decode
    wire apb_setup  = PSEL & ~PENABLE;
    wire apb_access = PSEL & PENABLE;
    wire hit_cfg    = PADDR == srm_pkg::OFF_CONFIG;
    wire hit_status = PADDR == srm_pkg::OFF_STATUS;
    wire hit_wcount = PADDR == srm_pkg::OFF_WCOUNT;
    wire hit_any    = hit_cfg | hit_status | hit_wcount;
    wire wr_take    = apb_access & PWRITE & CLK_EN & hit_any;
    wire wr_cfg     = wr_take & hit_cfg;
    wire wr_wcount  = wr_take & hit_wcount;

    // Zero wait states; a frozen block holds the master off
    assign PREADY  = CLK_EN;
    assign PSLVERR = apb_access & ~hit_any;
    assign PRDATA  = prdata_q;

    // Status word, sampled in the setup cycle
    logic [31:0] status_w;
    always_comb
    begin
        status_w = '0;
        status_w[srm_pkg::ST_MOD_SEL]                 = mod_sel;
        status_w[srm_pkg::ST_SEL_LSB +: NBLK]         = ~sel_n;
        status_w[srm_pkg::ST_RD_DRIVE]                = rd_drive;
        status_w[srm_pkg::ST_READY]                   = mem_ready;
        status_w[srm_pkg::ST_STROBE_LSB +: NBLK]      = ~strobe_n;
    end

    // Read data is loaded in the setup cycle so it is flop-driven
    always_comb
    begin
        prdata_d = prdata_q;
        if (apb_setup && !PWRITE)
        begin
            if (hit_cfg)
            begin
                prdata_d = cfg_q;
            end
            else if (hit_status)
            begin
                prdata_d = status_w;
            end
            else if (hit_wcount)
            begin
                prdata_d = {wcount_q[1], wcount_q[0]};
            end
            else
            begin
                prdata_d = '0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cfg_q    <= srm_pkg::CFG_RESET;
            prdata_q <= '0;
            dout_q   <= '0;
        end
        else if (CLK_EN)
        begin
            if (wr_cfg)
            begin
                cfg_q <= PWDATA;
            end
            prdata_q <= prdata_d;
            dout_q   <= read_word;
        end
    end

    // Write pulse counters; a pulse in the clearing cycle still counts
    generate
        for (gi = 0; gi < NBLK; gi++)
        begin : g_cnt
            logic [srm_pkg::CNT_W-1:0] cnt_d;
            always_comb
            begin
                cnt_d = wr_wcount ? '0 : wcount_q[gi];
                if (strobe_fall[gi])
                begin
                    cnt_d = cnt_d + 1'b1;
                end
            end

            always_ff @(posedge CLK or negedge RSTN)
            begin
                if (!RSTN)
                begin
                    wcount_q[gi]      <= '0;
                    strobe_prev_q[gi] <= 1'b1;
                end
                else if (CLK_EN)
                begin
                    wcount_q[gi]      <= cnt_d;
                    strobe_prev_q[gi] <= strobe_n[gi];
                end
            end
        end
    endgenerate
endmodule : srm_module

//--- srm_module_sva.sv
// Checker for the static RAM module control outputs.
// Assumes processor inputs change only just after rising CLK edges.
`timescale 1ns/1ns
module srm_checker (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic VALID_ACCESS_QUALIFIER,
    input wire logic READ_WRITE,
    input wire logic PHI2,
    input wire logic DATA_OE,
    input wire logic BLOCK_ONE_SELECT_N,
    input wire logic BLOCK_TWO_SELECT_N,
    input wire logic MODULE_SELECTED,
    input wire logic READ_DRIVE_ENABLE,
    input wire logic BLOCK_ONE_WRITE_STROBE,
    input wire logic BLOCK_TWO_WRITE_STROBE,
    input wire logic MEMORY_READY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    a_sel_valid: assert property (!BLOCK_ONE_SELECT_N |-> VALID_ACCESS_QUALIFIER)
        else $error("select without valid access");
    a_sel_drop: assert property ($fell(VALID_ACCESS_QUALIFIER) |->
        BLOCK_ONE_SELECT_N && BLOCK_TWO_SELECT_N) else $error("select outlived access");
    a_mod_sel: assert property (MODULE_SELECTED == (!BLOCK_ONE_SELECT_N || !BLOCK_TWO_SELECT_N))
        else $error("module selected wrong");
    a_read_drive: assert property (MODULE_SELECTED && READ_WRITE |-> READ_DRIVE_ENABLE)
        else $error("read drive missing");
    a_write_quiet: assert property (!READ_WRITE |-> !READ_DRIVE_ENABLE && !DATA_OE)
        else $error("drive during write");
    a_oe_match: assert property (DATA_OE == READ_DRIVE_ENABLE)
        else $error("data drive differs");
    a_read_hold: assert property (READ_WRITE |-> BLOCK_ONE_WRITE_STROBE && BLOCK_TWO_WRITE_STROBE)
        else $error("strobe during read");
    a_strobe_one: assert property (!BLOCK_ONE_WRITE_STROBE |-> PHI2 && VALID_ACCESS_QUALIFIER &&
        !BLOCK_ONE_SELECT_N) else $error("block one strobe ungated");
    a_strobe_two: assert property (!BLOCK_TWO_WRITE_STROBE |-> PHI2 && VALID_ACCESS_QUALIFIER &&
        !BLOCK_TWO_SELECT_N) else $error("block two strobe ungated");
    a_ready_slow: assert property (!MEMORY_READY |-> MODULE_SELECTED)
        else $error("ready low while idle");
    c_read: cover property (READ_DRIVE_ENABLE);
    c_write: cover property (!BLOCK_ONE_WRITE_STROBE);
    c_slow: cover property (!MEMORY_READY ##1 !MEMORY_READY);
endmodule : srm_checker

//--- srm_module_tb.sv
// Testbench: APB setup plus processor bus cycles with expected data.
// Assumes a 10 MHz clock and CLK_EN held high.
`timescale 1ns/1ns
module srm_module_tb;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err, boe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] addr;
    logic        valid, rw, phi2, oe, sel1_n, sel2_n, mod_sel, rde, strb1, strb2, ready;
    logic [7:0]  data_in, data_out, bd;
    int          num_errors, compares;
    initial clk = 1'b0;
    always #50 clk = ~clk;
    srm_module srm_module_inst (.CLK(clk), .RSTN(rstn), .CLK_EN(1'b1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ADDR(addr),
        .VALID_ACCESS_QUALIFIER(valid), .READ_WRITE(rw), .PHI2(phi2),
        .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(oe),
        .BLOCK_ONE_SELECT_N(sel1_n), .BLOCK_TWO_SELECT_N(sel2_n),
        .MODULE_SELECTED(mod_sel), .READ_DRIVE_ENABLE(rde),
        .BLOCK_ONE_WRITE_STROBE(strb1), .BLOCK_TWO_WRITE_STROBE(strb2),
        .MEMORY_READY(ready));
    srm_cpu_model srm_cpu_model_inst (.clk(clk), .data_out(data_out), .data_oe(oe),
        .memory_ready(ready), .addr(addr), .valid_access_qualifier(valid),
        .read_write(rw), .phi2(phi2), .data_in(data_in));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task cpu(input logic r, input logic [15:0] a, input logic [7:0] w);
        srm_cpu_model_inst.cycle(r, a, w, bd, boe);
    endtask : cpu
    task close_out;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    initial
    begin
        // About fifty times the expected run
        #(100 * 5000);
        num_errors++;
        close_out;
    end
    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        num_errors = 0;
        compares = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, srm_pkg::OFF_CONFIG, 32'h0); chk(rd, srm_pkg::CFG_RESET);
        apb(1'b0, 12'hFF0, 32'h0); chk(32'(err), 32'h1);
        cpu(1'b0, 16'h0010, 8'h5A);
        cpu(1'b0, 16'h0410, 8'hC3);
        cpu(1'b1, 16'h0010, 8'h00); chk(32'(bd), 32'h5A);
        chk(32'(boe), 32'h1);
        chk(32'(srm_cpu_model_inst.stretched), 32'h0);
        cpu(1'b1, 16'h0410, 8'h00); chk(32'(bd), 32'hC3);
        cpu(1'b1, 16'h0810, 8'h00); chk(32'(boe), 32'h0);
        // Block one moved to the top 1K, block two write protected
        apb(1'b1, srm_pkg::OFF_WCOUNT, 32'h0);
        apb(1'b1, srm_pkg::OFF_CONFIG, 32'h0002_013F);
        cpu(1'b0, 16'hFC20, 8'h96);
        cpu(1'b0, 16'h0410, 8'h11);
        cpu(1'b1, 16'hFC20, 8'h00); chk(32'(bd), 32'h96);
        cpu(1'b1, 16'h0410, 8'h00); chk(32'(bd), 32'hC3);
        apb(1'b0, srm_pkg::OFF_WCOUNT, 32'h0); chk(rd, 32'h0000_0001);
        // Slow parts: phase two stretched, still one strobe per cycle
        apb(1'b1, srm_pkg::OFF_CONFIG, 32'h0100_013F);
        cpu(1'b0, 16'h0430, 8'h3C);
        cpu(1'b1, 16'h0430, 8'h00); chk(32'(bd), 32'h3C);
        chk(32'(srm_cpu_model_inst.stretched), 32'h1);
        apb(1'b0, srm_pkg::OFF_WCOUNT, 32'h0); chk(rd, 32'h0001_0001);
        apb(1'b0, srm_pkg::OFF_STATUS, 32'h0); chk(rd, 32'h0000_0010);
        close_out;
    end
endmodule : srm_module_tb
bind srm_module srm_checker srm_checker_inst (.CLK(CLK), .RSTN(RSTN),
    .VALID_ACCESS_QUALIFIER(VALID_ACCESS_QUALIFIER), .READ_WRITE(READ_WRITE),
    .PHI2(PHI2), .DATA_OE(DATA_OE), .BLOCK_ONE_SELECT_N(BLOCK_ONE_SELECT_N),
    .BLOCK_TWO_SELECT_N(BLOCK_TWO_SELECT_N), .MODULE_SELECTED(MODULE_SELECTED),
    .READ_DRIVE_ENABLE(READ_DRIVE_ENABLE), .BLOCK_ONE_WRITE_STROBE(BLOCK_ONE_WRITE_STROBE),
    .BLOCK_TWO_WRITE_STROBE(BLOCK_TWO_WRITE_STROBE), .MEMORY_READY(MEMORY_READY));

//--- srm_pkg.sv
// Constants shared by the static RAM module control block.
// Assumes a 32-bit APB master and a processor bus sampled on CLK.
//
// Operation
// - Each block compares address bits 15..10 with its own base switches.
// - Block select is low only with valid access and matching upper address.
// - Module selected goes high whenever either block select is low.
// - Selected module with read/write high raises the read drive enable.
// - During a read both block write strobes stay high.
// - During a write the read drive enable stays low.
// - A block protected as ROM never gets a write strobe.
// - Write to selected unprotected block gates phase two onto its strobe.
// - Each block is 1024 by 8 storage, addressed by bits 9..0.
// - Data pins drive only while read drive enable is high.
// - With matching address, select follows the inverse of valid access.
// - With slow parts, memory ready is the inverse of module selected.
package srm_pkg;
    localparam int CLK_HZ         = 10_000_000;
    localparam int ADDR_W         = 16;
    localparam int BLK_AW         = 10;
    localparam int DATA_W         = 8;
    localparam int NUM_BLK        = 2;
    localparam int PADDR_W        = 12;
    localparam int CNT_W          = 16;

    // Register byte offsets
    localparam logic [11:0] OFF_CONFIG = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_WCOUNT = 12'h008;

    // Config fields: base switches per block, protect bits, slow parts
    localparam int CFG_BASE_STRIDE = 8;
    localparam int CFG_PROT_LSB    = 16;
    localparam int CFG_SLOW_BIT    = 24;
    localparam logic [31:0] CFG_RESET = 32'h0000_0100;

    // Status fields
    localparam int ST_MOD_SEL   = 0;
    localparam int ST_SEL_LSB   = 1;
    localparam int ST_RD_DRIVE  = 3;
    localparam int ST_READY     = 4;
    localparam int ST_STROBE_LSB = 5;
endpackage : srm_pkg

//--- srm_select.sv
// Base address compare for one memory block.
// Assumes the upper address and access qualifier are stable within a cycle.
`timescale 1ns/1ns
module srm_select #(
    parameter int SEL_W = 6
) (
    input  wire logic [SEL_W-1:0] upper_addr,
    input  wire logic [SEL_W-1:0] base_sw,
    input  wire logic             valid_access_qualifier,
    output logic                  select_n
);
    // A set switch passes the true bit, a clear one its complement
    wire [SEL_W-1:0] bit_match = ~(upper_addr ^ base_sw);
    wire             addr_hit  = &bit_match;

    // Combinational so it tracks the qualifier until the address moves
    assign select_n = ~(addr_hit & valid_access_qualifier);
endmodule : srm_select
